// *** out_dly_pkg.sv ***
// Purpose: shared constants and types for the output transition delay block
// Assumes: 50 MHz pclk, delays held in tenths of a second
// Notes: register offsets are byte addresses on a 32-bit apb bus
package out_dly_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 100; // delay step in milliseconds
    localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
    localparam int DLY_W = 10;
    localparam logic [9:0] DLY_MAX = 10'h3E8; // 100.0 s in tenths
    localparam logic [9:0] DLY_RST = 10'h000;
    localparam int N_OUT = 3; // term a, term b, relay
    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_RLY = 2;
    // register offsets
    localparam logic [7:0] FUNC_OFS = 8'h00;
    localparam logic [7:0] A_RISE_OFS = 8'h04;
    localparam logic [7:0] A_FALL_OFS = 8'h08;
    localparam logic [7:0] B_RISE_OFS = 8'h0C;
    localparam logic [7:0] B_FALL_OFS = 8'h10;
    localparam logic [7:0] R_RISE_OFS = 8'h14;
    localparam logic [7:0] R_FALL_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1C;
    // function select field: two bits per output
    localparam int FUNC_W = 2;
    localparam logic [1:0] FN_RUN = 2'h0;
    localparam logic [1:0] FN_EXT = 2'h1;
    localparam logic [5:0] FUNC_RST = 6'h00;
    // status field positions
    localparam int ST_FILT = 0;
    localparam int ST_SRC = 3;
    localparam int ST_RUN = 6;
    typedef struct packed {
        logic [DLY_W-1:0] rise;
        logic [DLY_W-1:0] fall;
    } dly_pair_t;
endpackage

// *** dly_filter.sv ***
// Purpose: one output's rise/fall transition delay filter
// Assumes: src is synchronous to pclk
// Notes: delay is exact to the cycle: setting times tick_cycles
`timescale 1ns/100ps
module dly_filter
    import out_dly_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src,
    input wire dly_pair_t dly,
    output logic filt_r
);
    logic [31:0] pre_r;
    logic [DLY_W-1:0] ten_r;
    logic [DLY_W-1:0] tgt;
    logic pre_end;
    logic ten_end;

    // pick the delay for the pending edge
    assign tgt = src ? dly.rise : dly.fall;
    assign pre_end = (pre_r == 32'(TICK_CYCLES - 1));
    assign ten_end = (ten_r >= tgt - 10'h001); // a delay cut below the count so far ends at the next tick

    // output level: moves only when the mismatch has lasted the full delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= 1'b0;
        end else if (src != filt_r) begin
            if (tgt == DLY_RST) begin
                filt_r <= src;
            end else if (pre_end && ten_end) begin
                filt_r <= src;
            end
        end
    end

    // per-output prescaler restarts with each new pending edge, so the
    // delay never loses part of a tick to a shared divider phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 32'h0;
            ten_r <= DLY_RST;
        end else if (src == filt_r || tgt == DLY_RST) begin
            pre_r <= 32'h0;
            ten_r <= DLY_RST;
        end else if (pre_end) begin
            pre_r <= 32'h0;
            ten_r <= ten_end ? DLY_RST : ten_r + 10'h001;
        end else begin
            pre_r <= pre_r + 32'h1;
        end
    end

    property p_zero_pass;
        @(posedge pclk) disable iff (!presetn)
        (src != filt_r && tgt == DLY_RST) |=> (filt_r == $past(src));
    endproperty
    a_zero_pass: assert property (p_zero_pass) else $error("zero delay edge not passed");

    property p_early;
        @(posedge pclk) disable iff (!presetn)
        (src != filt_r && tgt != DLY_RST && !(pre_end && ten_end)) |=> (filt_r == $past(filt_r));
    endproperty
    a_early: assert property (p_early) else $error("output moved before delay ran out");

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        (src == filt_r) |=> (ten_r == DLY_RST && pre_r == 32'h0 && filt_r == $past(filt_r));
    endproperty
    a_restart: assert property (p_restart) else $error("cancelled edge left count or moved output");
endmodule

// *** out_dly_top.sv ***
// Purpose: intelligent output delay block with apb register access
// Assumes: run_mode and ext_src come from logic on pclk
// Notes: open collector pins pull low while asserted
// Functional notes
// - each of the three outputs has its own independent rise and fall delay.
// - a nonzero delay ranges from 0.1 s to 100.0 s.
// - with a rise delay the output asserts only after the source held high for the whole delay.
// - a high pulse shorter than the rise delay never reaches the output.
// - with a fall delay the output drops only after the source held low for the whole delay.
// - a low gap shorter than the fall delay never reaches the output.
// - rise and fall delays act together on the same output.
// - terminal a has rise and fall settings of 0 to 100 s, reset to zero.
// - terminal b has rise and fall settings of 0 to 100 s, reset to zero.
// - the relay has rise and fall settings of 0 to 100 s, reset to zero.
// - the filter sits after the function select for every function.
// - function code 00 asserts the output while the drive runs.
// - the run output is active low, pulling the pin to ground.
// - the run output is deasserted while the drive is stopped.
`timescale 1ns/100ps
module out_dly_top
    import out_dly_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_mode,
    input wire logic [N_OUT-1:0] ext_src,
    output logic [1:0] oc_o,
    output logic [1:0] oc_oe,
    output logic relay_coil
);
    dly_pair_t dly_r [N_OUT];
    logic [3*FUNC_W-1:0] func_r;
    logic [N_OUT-1:0] src;
    logic [N_OUT-1:0] filt;
    logic acc;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [DLY_W-1:0] wdly;
    logic [31:0] rd_nxt;

    // an access completes on the second access cycle, when pready is high
    assign acc = psel && penable;
    assign wr_en = acc && pwrite && pready;
    assign rd_en = acc && !pwrite && !pready;

    // clip writes above the top of range instead of rejecting them,
    // so software always ends up with a legal delay
    assign wdly = (pwdata > 32'(DLY_MAX)) ? DLY_MAX : pwdata[DLY_W-1:0];

    // decode of the mapped offsets
    always_comb begin
        unique case (paddr)
            FUNC_OFS, A_RISE_OFS, A_FALL_OFS, B_RISE_OFS: hit = 1'b1;
            B_FALL_OFS, R_RISE_OFS, R_FALL_OFS, STAT_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // read mux, narrow fields in the low bits, upper bits read as zero
    always_comb begin
        rd_nxt = 32'h0;
        unique case (paddr)
            FUNC_OFS: rd_nxt[5:0] = func_r;
            A_RISE_OFS: rd_nxt[DLY_W-1:0] = dly_r[OUT_A].rise;
            A_FALL_OFS: rd_nxt[DLY_W-1:0] = dly_r[OUT_A].fall;
            B_RISE_OFS: rd_nxt[DLY_W-1:0] = dly_r[OUT_B].rise;
            B_FALL_OFS: rd_nxt[DLY_W-1:0] = dly_r[OUT_B].fall;
            R_RISE_OFS: rd_nxt[DLY_W-1:0] = dly_r[OUT_RLY].rise;
            R_FALL_OFS: rd_nxt[DLY_W-1:0] = dly_r[OUT_RLY].fall;
            STAT_OFS: begin
                rd_nxt[ST_FILT +: N_OUT] = filt;
                rd_nxt[ST_SRC +: N_OUT] = src;
                rd_nxt[ST_RUN] = run_mode;
            end
            default: rd_nxt = 32'h0;
        endcase
    end

    // bus handshake: one wait state, pready high for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && !hit;
        end
    end

    // read data captured ahead of the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= hit ? rd_nxt : 32'h0;
        end
    end

    // function select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_r <= FUNC_RST;
        end else if (wr_en && paddr == FUNC_OFS) begin
            func_r <= pwdata[5:0];
        end
    end

    // delay settings, all zero after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N_OUT; i++) begin
                dly_r[i] <= '{rise: DLY_RST, fall: DLY_RST};
            end
        end else if (wr_en) begin
            unique case (paddr)
                A_RISE_OFS: dly_r[OUT_A].rise <= wdly;
                A_FALL_OFS: dly_r[OUT_A].fall <= wdly;
                B_RISE_OFS: dly_r[OUT_B].rise <= wdly;
                B_FALL_OFS: dly_r[OUT_B].fall <= wdly;
                R_RISE_OFS: dly_r[OUT_RLY].rise <= wdly;
                R_FALL_OFS: dly_r[OUT_RLY].fall <= wdly;
                default: ;
            endcase
        end
    end

    // per output: function select, then its own delay filter
    for (genvar g = 0; g < N_OUT; g++) begin : g_out
        logic [1:0] fsel;
        assign fsel = func_r[g*FUNC_W +: FUNC_W];
        // run status follows the drive mode: high in run, low in stop
        assign src[g] = (fsel == FN_RUN) ? run_mode :
                        (fsel == FN_EXT) ? ext_src[g] : 1'b0;
        dly_filter #(
            .TICK_CYCLES(TICK_CYCLES)
        ) u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .src(src[g]),
            .dly(dly_r[g]),
            .filt_r(filt[g])
        );

        // checker side of this output: the delay setting for the pending edge and
        // the number of edges that its delay allows
        logic [DLY_W-1:0] chk_tgt;
        logic [39:0] chk_lim;
        logic [39:0] mis_cnt_r;
        assign chk_tgt = src[g] ? dly_r[g].rise : dly_r[g].fall;
        assign chk_lim = 40'(chk_tgt) * 40'(TICK_CYCLES); // 100 s at full rate overflows 32 bits

        // edges with source and output apart, restarted once they agree
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mis_cnt_r <= 40'h0;
            end else if (src[g] != filt[g]) begin
                mis_cnt_r <= mis_cnt_r + 40'h1;
            end else begin
                mis_cnt_r <= 40'h0;
            end
        end

        // never early: no move while the count is short of the delay
        property p_no_early;
            @(posedge pclk) disable iff (!presetn)
            (src[g] != filt[g] && chk_tgt != DLY_RST && mis_cnt_r + 40'h1 < chk_lim)
                |=> (filt[g] == $past(filt[g]));
        endproperty
        a_no_early: assert property (p_no_early) else $error("output moved before its delay ran out");

        // never late: the output has followed once the delay runs out
        property p_no_late;
            @(posedge pclk) disable iff (!presetn)
            (src[g] != filt[g]) |-> (mis_cnt_r <= chk_lim);
        endproperty
        a_no_late: assert property (p_no_late) else $error("output lags beyond its delay");

        // the ext code hands the output its own source
        property p_ext_sel;
            @(posedge pclk) disable iff (!presetn)
            (fsel == FN_EXT) |-> (src[g] == ext_src[g]);
        endproperty
        a_ext_sel: assert property (p_ext_sel) else $error("ext function not selected");

        // the two spare codes hold the source off
        property p_spare_off;
            @(posedge pclk) disable iff (!presetn)
            (fsel != FN_RUN && fsel != FN_EXT) |-> !src[g];
        endproperty
        a_spare_off: assert property (p_spare_off) else $error("spare function code drives the source");

        // run code follows the drive mode on every output, relay included
        property p_run_sel;
            @(posedge pclk) disable iff (!presetn)
            (fsel == FN_RUN) |-> (src[g] == run_mode);
        endproperty
        a_run_sel: assert property (p_run_sel) else $error("run function not following drive mode");

        // clipping keeps every stored delay inside the legal range
        property p_in_range;
            @(posedge pclk) disable iff (!presetn)
            (dly_r[g].rise <= DLY_MAX && dly_r[g].fall <= DLY_MAX);
        endproperty
        a_in_range: assert property (p_in_range) else $error("stored delay out of range");
    end

    // pins: the transistor sinks to ground while the output is asserted;
    // one extra flop keeps every pin straight off a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_o <= 2'h0;
            oc_oe <= 2'h0;
            relay_coil <= 1'b0;
        end else begin
            oc_o <= 2'h0;
            oc_oe <= filt[OUT_B:OUT_A];
            relay_coil <= filt[OUT_RLY];
        end
    end

    // bus phases for the handshake checks
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence

    property p_one_wait;
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_wait |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait cycle");

    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held over two cycles");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (s_wait and (!hit)) |=> (pslverr && pready);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    property p_clip;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == A_RISE_OFS && pwdata > 32'(DLY_MAX)) |=> (dly_r[OUT_A].rise == DLY_MAX);
    endproperty
    a_clip: assert property (p_clip) else $error("delay above range not clipped");

    property p_run_src;
        @(posedge pclk) disable iff (!presetn)
        (func_r[1:0] == FN_RUN) |-> (src[OUT_A] == run_mode);
    endproperty
    a_run_src: assert property (p_run_src) else $error("run function not following drive mode");

    property p_stop_off;
        @(posedge pclk) disable iff (!presetn)
        (func_r[1:0] == FN_RUN && dly_r[OUT_A].fall == DLY_RST && !run_mode && !filt[OUT_A])
            [*2] |=> !oc_oe[OUT_A];
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("run output on in stop mode");

    property p_pin_follow;
        @(posedge pclk) disable iff (!presetn)
        ##1 (oc_oe == $past(filt[OUT_B:OUT_A]) && oc_o == 2'h0 && relay_coil == $past(filt[OUT_RLY]));
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pins not driven from filter");

    property p_dly_zero_rst;
        @(posedge pclk)
        $rose(presetn) |-> (dly_r[OUT_B].rise == DLY_RST && dly_r[OUT_RLY].fall == DLY_RST);
    endproperty
    a_dly_zero_rst: assert property (p_dly_zero_rst) else $error("delay not zero after reset");

    // a completed access: pready sampled high with the request still up
    sequence s_done;
        psel && penable && pready;
    endsequence

    // an error is only ever reported on the completing cycle
    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error flag without ready");

    // unmapped reads return zero rather than stale data
    property p_unmapped_rd;
        @(posedge pclk) disable iff (!presetn)
        (s_wait and (!hit && !pwrite)) |=> (prdata == 32'h0);
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read data not zero");

    // function select lands on the completing edge
    property p_func_wr;
        @(posedge pclk) disable iff (!presetn)
        (s_done and (pwrite && paddr == FUNC_OFS)) |=> (func_r == $past(pwdata[5:0]));
    endproperty
    a_func_wr: assert property (p_func_wr) else $error("function write lost");

    // an in-range delay is stored exactly as written
    property p_a_fall_wr;
        @(posedge pclk) disable iff (!presetn)
        (s_done and (pwrite && paddr == A_FALL_OFS && pwdata <= 32'(DLY_MAX)))
            |=> (dly_r[OUT_A].fall == $past(pwdata[DLY_W-1:0]));
    endproperty
    a_a_fall_wr: assert property (p_a_fall_wr) else $error("terminal a fall delay write lost");

    // same for the second terminal's rise delay
    property p_b_rise_wr;
        @(posedge pclk) disable iff (!presetn)
        (s_done and (pwrite && paddr == B_RISE_OFS && pwdata <= 32'(DLY_MAX)))
            |=> (dly_r[OUT_B].rise == $past(pwdata[DLY_W-1:0]));
    endproperty
    a_b_rise_wr: assert property (p_b_rise_wr) else $error("terminal b rise delay write lost");

    // and for the relay's fall delay
    property p_r_fall_wr;
        @(posedge pclk) disable iff (!presetn)
        (s_done and (pwrite && paddr == R_FALL_OFS && pwdata <= 32'(DLY_MAX)))
            |=> (dly_r[OUT_RLY].fall == $past(pwdata[DLY_W-1:0]));
    endproperty
    a_r_fall_wr: assert property (p_r_fall_wr) else $error("relay fall delay write lost");

    // read data on the completing cycle matches the stored setting
    property p_rd_relay_rise;
        @(posedge pclk) disable iff (!presetn)
        (s_done and (!pwrite && paddr == R_RISE_OFS)) |-> (prdata == {22'h0, dly_r[OUT_RLY].rise});
    endproperty
    a_rd_relay_rise: assert property (p_rd_relay_rise) else $error("relay rise delay read wrong");
endmodule

// *** ext_equip.sv ***
// Purpose: external wiring seen by the output terminals and the relay
// Assumes: pull-up on each open collector line, relay contact follows the coil
// Notes: a released line reads high, never the last driven value
`timescale 1ns/100ps
module ext_equip (
    input wire logic [1:0] oc_o,
    input wire logic [1:0] oc_oe,
    input wire logic relay_coil,
    output logic [1:0] pin_lvl,
    output logic no_contact
);
    // pull-up wins whenever the transistor is off
    assign pin_lvl[0] = oc_oe[0] ? oc_o[0] : 1'b1;
    assign pin_lvl[1] = oc_oe[1] ? oc_o[1] : 1'b1;
    // normally open contact closes with the coil
    assign no_contact = relay_coil;
endmodule

// *** out_dly_top_test.sv ***
// Purpose: self-checking bench for the output delay block
// Assumes: tick shortened to 4 cycles so delays of a few tenths stay short
// Notes: pin outputs are read 1 ns after an edge, bus outputs at the edge itself, inputs change at the edge
`timescale 1ns/100ps
module out_dly_top_test;
    import out_dly_pkg::*;
    localparam int TK = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run_mode = 1'b0;
    logic [2:0] ext_src = 3'h0;
    logic [1:0] oc_o;
    logic [1:0] oc_oe;
    logic relay_coil;
    logic [1:0] pin_lvl;
    logic no_contact;
    logic [31:0] rd_q;
    logic er_q;
    int n_errors = 0;
    int n_compared = 0;
    out_dly_top #(.TICK_CYCLES(TK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_mode(run_mode), .ext_src(ext_src),
        .oc_o(oc_o), .oc_oe(oc_oe), .relay_coil(relay_coil));
    ext_equip eq_u (.oc_o(oc_o), .oc_oe(oc_oe), .relay_coil(relay_coil),
        .pin_lvl(pin_lvl), .no_contact(no_contact));
    // free running 50 MHz clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; an edge passes first so psel is never assigned twice in a step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k == 20) begin
            n_errors++;
            $display("Error at %0t: no pready", $time);
        end
        rd_q = prdata;
        er_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        apb(1'b1, a, d);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
        chk({31'h0, er_q}, 32'h0);
    endtask
    task drv(input logic [2:0] v);
        @(posedge pclk);
        ext_src <= v;
    endtask
    // check relay and both enables after each of n edges
    task hold(input int n, input logic [2:0] exp);
        repeat (n) begin
            @(posedge pclk);
            #1;
            chk({29'h0, relay_coil, oc_oe}, {29'h0, exp});
        end
    endtask
    task test_regs;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd_q, 32'h0);
        end
        wr_rd(A_RISE_OFS, 32'h00000FFF, 32'h000003E8);
        wr_rd(A_RISE_OFS, 32'h00010005, 32'h000003E8);
        wr_rd(B_FALL_OFS, 32'h000003E9, 32'h000003E8);
        wr_rd(R_RISE_OFS, 32'h000003E8, 32'h000003E8);
        wr_rd(R_FALL_OFS, 32'h00000001, 32'h00000001);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd_q, 32'h0);
        chk({31'h0, er_q}, 32'h1);
        $display("test_regs done");
    endtask
    task test_run;
        wr_rd(A_RISE_OFS, 32'h0, 32'h0);
        wr_rd(R_RISE_OFS, 32'h0, 32'h0);
        wr_rd(R_FALL_OFS, 32'h0, 32'h0);
        wr_rd(B_FALL_OFS, 32'h0, 32'h0);
        @(posedge pclk);
        run_mode <= 1'b1;
        hold(1, 3'h0);
        hold(1, 3'h7);
        chk({28'h0, oc_o, pin_lvl}, 32'h0);
        chk({31'h0, no_contact}, 32'h1);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd_q, 32'h0000007F);
        @(posedge pclk);
        run_mode <= 1'b0;
        hold(1, 3'h7);
        hold(1, 3'h0);
        chk({30'h0, pin_lvl}, 32'h3);
        chk({31'h0, no_contact}, 32'h0);
        $display("test_run done");
    endtask
    // a: rise 2 fall 1 ticks, b: none, relay: rise 1, all from ext_src
    task test_edges;
        wr_rd(FUNC_OFS, 32'h15, 32'h15);
        wr_rd(A_RISE_OFS, 32'h2, 32'h2);
        wr_rd(A_FALL_OFS, 32'h1, 32'h1);
        wr_rd(B_FALL_OFS, 32'h0, 32'h0);
        wr_rd(R_RISE_OFS, 32'h1, 32'h1);
        drv(3'h1);
        hold(6, 3'h0);
        drv(3'h0);
        hold(12, 3'h0);
        drv(3'h7);
        hold(1, 3'h0);
        hold(3, 3'h2);
        hold(4, 3'h6);
        hold(1, 3'h7);
        drv(3'h6);
        hold(2, 3'h7);
        drv(3'h7);
        hold(10, 3'h7);
        drv(3'h0);
        hold(1, 3'h7);
        hold(3, 3'h1);
        hold(1, 3'h0);
        $display("test_edges done");
    endtask
    task test_forced;
        wr_rd(FUNC_OFS, 32'h3A, 32'h3A);
        drv(3'h7);
        run_mode <= 1'b1;
        hold(12, 3'h0);
        $display("test_forced done");
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_run();
        test_edges();
        test_forced();
        end_sim();
    end
endmodule
